// ==== brtc_regs.svh ====
// Operation
// - Count retries per forwarded cycle; at the selected limit stop and flag timeout.
// - Retry timeout raises system error on a port only where enabled.
// - Limit codes 0,1,2,3,7 give 2^24,2^18,2^12,2^6,2^0; field resets zero.
// - Primary divider code 11,10,01,00 divides by 256,16,8,1.
// - Secondary divider uses the same codes as the primary divider.
// - Base master timeout length is 32K, or 1K when selected.
// - Effective master timeout is base length divided by selected divisor.
// - Both divider fields reset to 00.
`ifndef BRTC_REGS_SVH
`define BRTC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BRTC_OFF_CTRL       8'h00
`define BRTC_OFF_STATUS     8'h04
`define BRTC_OFF_MASK       8'h08
`define BRTC_OFF_ENABLE     8'h0C
`define BRTC_OFF_STATE      8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BRTC_LIMIT_LSB      0
`define BRTC_RSVD_BIT       3
`define BRTC_PDIV_LSB       4
`define BRTC_SDIV_LSB       6
`define BRTC_CTRL_RESET     8'h00
`define BRTC_MASK_RESET     4'h0
`define BRTC_ENABLE_RESET   3'h0

// ----------------------------------------------------------------
// Timing counts in PCI clocks
// ----------------------------------------------------------------
`define BRTC_BASE_LONG      16'h8000
`define BRTC_BASE_SHORT     16'h0400

`endif

// ==== brtc_pkg.sv ====
package brtc_pkg;
    typedef enum logic [1:0]
    {
        BRTC_DIV1   = 2'b00,
        BRTC_DIV8   = 2'b01,
        BRTC_DIV16  = 2'b10,
        BRTC_DIV256 = 2'b11
    } brtc_div_t;

    typedef enum logic [1:0]
    {
        BRTC_IDLE = 2'b00,
        BRTC_RUN  = 2'b01,
        BRTC_TOUT = 2'b10
    } brtc_state_t;
endpackage : brtc_pkg

// ==== brtc_top.sv ====
`timescale 1ns/10ps
`include "brtc_regs.svh"

module brtc_top
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Retry events from the forwarding engine (same clock)
    input  wire logic        cycStart,
    input  wire logic        cycRetry,
    input  wire logic        cycDone,
    input  wire logic        cycIsPrimary,
    // Master timeout pacing (same clock)
    input  wire logic        priMtStart,
    input  wire logic        secMtStart,
    input  wire logic        mtShortSel,
    // Results
    output logic             retryStop_r,
    output logic             priSerr_r,
    output logic             secSerr_r,
    output logic             priMtExpire_r,
    output logic             secMtExpire_r,
    output logic             irq_r
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta_r;
    logic rstSync_r;

    // Release is delayed two clocks so every flop leaves reset together
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_r;
    logic [3:0]  status_r;
    logic [3:0]  mask_r;
    logic [2:0]  enable_r;   // [0] pri serr, [1] sec serr, [2] stored and readable but unused
    logic [24:0] retryCnt_r;
    logic [15:0] priCnt_r;
    logic [15:0] secCnt_r;
    logic        priRun_r;
    logic        secRun_r;
    brtc_pkg::brtc_state_t state_r;

    logic        wrFire;
    logic        haveAw_r;
    logic        haveW_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        tout;
    logic        priEnd;
    logic        secEnd;
    logic [3:0]  evt;

    assign wrFire = haveAw_r && haveW_r && !bvalid;

    // Write channels accepted in either order, held until response
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            haveAw_r <= 1'b0;
            haveW_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= 2'b00;
        end
        else
        begin
            awready <= !haveAw_r && !awready && awvalid;
            wready  <= !haveW_r && !wready && wvalid;
            if (awvalid && awready)
            begin
                haveAw_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready)
            begin
                haveW_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (wrFire)
            begin
                bvalid   <= 1'b1;
                bresp    <= (awAddr_r == `BRTC_OFF_CTRL || awAddr_r == `BRTC_OFF_STATUS
                             || awAddr_r == `BRTC_OFF_MASK || awAddr_r == `BRTC_OFF_ENABLE
                             || awAddr_r == `BRTC_OFF_STATE) ? 2'b00 : 2'b10;
                haveAw_r <= 1'b0;
                haveW_r  <= 1'b0;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // Control register; reserved bit never stored
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            ctrl_r   <= `BRTC_CTRL_RESET;
            mask_r   <= `BRTC_MASK_RESET;
            enable_r <= `BRTC_ENABLE_RESET;
        end
        else if (wrFire && wStrb_r[0])
        begin
            if (awAddr_r == `BRTC_OFF_CTRL)
            begin
                ctrl_r <= wData_r[7:0] & 8'hF7;
            end
            if (awAddr_r == `BRTC_OFF_MASK)
            begin
                mask_r <= wData_r[3:0];
            end
            if (awAddr_r == `BRTC_OFF_ENABLE)
            begin
                enable_r <= wData_r[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Retry counter
    // ------------------------------------------------------------
    function automatic logic [24:0] limitOf(input logic [2:0] code);
        logic [24:0] lim;
        lim = 25'h000_0000;
        unique case (code)
            3'h0:    lim = 25'h100_0000;
            3'h1:    lim = 25'h004_0000;
            3'h2:    lim = 25'h000_1000;
            3'h3:    lim = 25'h000_0040;
            3'h7:    lim = 25'h000_0001;
            default: lim = 25'h100_0000; // Undefined codes fall back to the longest
        endcase
        return lim;
    endfunction : limitOf

    assign tout = (state_r == brtc_pkg::BRTC_RUN) && cycRetry
                  && (retryCnt_r + 25'h000_0001 >= limitOf(ctrl_r[2:0]));

    // Count per cycle; a new or finished cycle restarts from zero
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            state_r     <= brtc_pkg::BRTC_IDLE;
            retryCnt_r  <= 25'h000_0000;
            retryStop_r <= 1'b0;
        end
        else
        begin
            retryStop_r <= 1'b0;
            if (cycDone || cycStart)
            begin
                retryCnt_r <= 25'h000_0000;
                state_r    <= cycStart ? brtc_pkg::BRTC_RUN : brtc_pkg::BRTC_IDLE;
            end
            else if (tout)
            begin
                state_r     <= brtc_pkg::BRTC_TOUT;
                retryStop_r <= 1'b1;
            end
            else if (state_r == brtc_pkg::BRTC_RUN && cycRetry)
            begin
                retryCnt_r <= retryCnt_r + 25'h000_0001;
            end
        end
    end

    // System-error pulses per port, gated by the event enables
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            priSerr_r <= 1'b0;
            secSerr_r <= 1'b0;
        end
        else
        begin
            priSerr_r <= tout && cycIsPrimary && enable_r[0];
            secSerr_r <= tout && !cycIsPrimary && enable_r[1];
        end
    end

    // ------------------------------------------------------------
    // Master timeout counters
    // ------------------------------------------------------------
    function automatic logic [15:0] mtLen(input logic sel, input logic [1:0] div);
        logic [15:0] base;
        base = sel ? `BRTC_BASE_SHORT : `BRTC_BASE_LONG;
        unique case (brtc_pkg::brtc_div_t'(div))
            brtc_pkg::BRTC_DIV1:   return base;
            brtc_pkg::BRTC_DIV8:   return base >> 3;
            brtc_pkg::BRTC_DIV16:  return base >> 4;
            brtc_pkg::BRTC_DIV256: return base >> 8;
        endcase
        return base;
    endfunction : mtLen

    // A restart reloads the counter, so the run it replaces never expires
    assign priEnd = priRun_r && (priCnt_r == 16'h0001) && !priMtStart;
    assign secEnd = secRun_r && (secCnt_r == 16'h0001) && !secMtStart;

    // Load on start, count down, pulse at expiry
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            priCnt_r      <= 16'h0000;
            secCnt_r      <= 16'h0000;
            priRun_r      <= 1'b0;
            secRun_r      <= 1'b0;
            priMtExpire_r <= 1'b0;
            secMtExpire_r <= 1'b0;
        end
        else
        begin
            priMtExpire_r <= priEnd;
            secMtExpire_r <= secEnd;
            if (priMtStart)
            begin
                priCnt_r <= mtLen(mtShortSel, ctrl_r[`BRTC_PDIV_LSB +: 2]);
                priRun_r <= 1'b1;
            end
            else if (priRun_r)
            begin
                priCnt_r <= priCnt_r - 16'h0001;
                priRun_r <= !priEnd;
            end
            if (secMtStart)
            begin
                secCnt_r <= mtLen(mtShortSel, ctrl_r[`BRTC_SDIV_LSB +: 2]);
                secRun_r <= 1'b1;
            end
            else if (secRun_r)
            begin
                secCnt_r <= secCnt_r - 16'h0001;
                secRun_r <= !secEnd;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status: set wins over write-one-to-clear
    // ------------------------------------------------------------
    assign evt = {secEnd, priEnd, tout && !cycIsPrimary, tout && cycIsPrimary};

    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            status_r <= 4'h0;
            irq_r    <= 1'b0;
        end
        else
        begin
            if (wrFire && wStrb_r[0] && awAddr_r == `BRTC_OFF_STATUS)
            begin
                status_r <= (status_r & ~wData_r[3:0]) | evt;
            end
            else
            begin
                status_r <= status_r | evt;
            end
            irq_r <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // Read channel, one cycle after address
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= 2'b00;
        end
        else
        begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rresp  <= 2'b00;
                unique case (araddr)
                    `BRTC_OFF_CTRL:   rdata <= {24'h00_0000, ctrl_r};
                    `BRTC_OFF_STATUS: rdata <= {28'h000_0000, status_r};
                    `BRTC_OFF_MASK:   rdata <= {28'h000_0000, mask_r};
                    `BRTC_OFF_ENABLE: rdata <= {29'h000_0000, enable_r};
                    `BRTC_OFF_STATE:  rdata <= {5'h00, state_r, retryCnt_r};
                    default:
                    begin
                        rdata <= 32'h0000_0000;
                        rresp <= 2'b10;
                    end
                endcase
            end
            else if (rvalid && rready)
            begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : brtc_top

// ==== brtc_top_asserts.sv ====
`timescale 1ns/10ps

module brtc_top_chk
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Event inputs
    input wire logic cycStart,
    input wire logic cycRetry,
    input wire logic priMtStart,
    input wire logic secMtStart,
    // Results
    input wire logic retryStop_r,
    input wire logic priSerr_r,
    input wire logic secSerr_r,
    input wire logic priMtExpire_r,
    input wire logic secMtExpire_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Retry limit
    // ------------------------------------------------------------
    stop_has_retry_a: assert property (retryStop_r |-> $past(cycRetry))
        else $error("retry stop without a retry");
    stop_one_shot_a: assert property (retryStop_r |=> !retryStop_r)
        else $error("retry stop longer than one cycle");
    pri_serr_stop_a: assert property (priSerr_r |-> retryStop_r)
        else $error("primary system error without retry stop");
    sec_serr_stop_a: assert property (secSerr_r |-> retryStop_r)
        else $error("secondary system error without retry stop");
    // A new cycle wins over a timeout in the same clock, so no stop can follow it
    new_cycle_quiet_a: assert property (cycStart |=> !retryStop_r)
        else $error("retry stop right after a new cycle");

    // ------------------------------------------------------------
    // Master timeout: shortest length is 1K / 256 = 4 cycles
    // ------------------------------------------------------------
    pri_mt_min_a: assert property (priMtStart |=> !priMtExpire_r [*3])
        else $error("primary master timeout too short");
    sec_mt_min_a: assert property (secMtStart |=> !secMtExpire_r [*3])
        else $error("secondary master timeout too short");
    mt_one_shot_a: assert property (priMtExpire_r |=> !priMtExpire_r)
        else $error("primary expiry longer than one cycle");
endmodule : brtc_top_chk

bind brtc_top brtc_top_chk chk
(
    .ref_clk, .rst_b, .cycStart, .cycRetry, .priMtStart, .secMtStart,
    .retryStop_r, .priSerr_r, .secSerr_r, .priMtExpire_r, .secMtExpire_r
);

// ==== brtc_agent.sv ====
`timescale 1ns/10ps

module brtc_agent
(
    // Clock and answer
    input wire logic ref_clk,
    input wire logic retryStop_r,
    // Cycle events
    output logic     cycStart,
    output logic     cycRetry,
    output logic     cycDone,
    output logic     cycIsPrimary
);
    logic stopSeen;

    initial
    begin
        {cycStart, cycRetry, cycDone, cycIsPrimary} = 4'h0;
    end

    // Sticky stop flag, cleared by each new cycle
    always @(posedge ref_clk)
    begin
        if (cycStart) stopSeen <= 1'b0;
        else if (retryStop_r) stopSeen <= 1'b1;
    end

    // One cycle: start, retries until stopped or maxN, then done
    task automatic run(input logic pri, input int maxN, output int n);
        n = 0;
        @(posedge ref_clk);
        cycIsPrimary <= pri;
        cycStart     <= 1'b1;
        @(posedge ref_clk);
        cycStart <= 1'b0;
        // One more edge so the stop flag of the previous cycle reads cleared
        @(posedge ref_clk);
        while (n < maxN && stopSeen !== 1'b1)
        begin
            cycRetry <= 1'b1;
            @(posedge ref_clk);
            cycRetry <= 1'b0;
            n++;
            repeat (3) @(posedge ref_clk); // Stop lands one cycle after the retry
        end
        cycDone <= 1'b1;
        @(posedge ref_clk);
        cycDone <= 1'b0;
    endtask : run
endmodule : brtc_agent

// ==== bridge_retry_timeout_control_test.sv ====
`timescale 1ns/10ps

module bridge_retry_timeout_control_test;
    logic ref_clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, priMtStart = 0, secMtStart = 0, mtShortSel = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, lastB;
    logic awready, wready, bvalid, arready, rvalid, cycStart, cycRetry, cycDone, cycIsPrimary;
    logic retryStop_r, priSerr_r, secSerr_r, priMtExpire_r, secMtExpire_r, irq_r, irqA;
    logic priSeen, secSeen;
    int failures = 0, n_tests = 0, n;
    int shf[4] = '{0, 3, 4, 8};

    brtc_top uut
    (
        .ref_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .cycStart, .cycRetry, .cycDone, .cycIsPrimary, .priMtStart, .secMtStart,
        .mtShortSel, .retryStop_r, .priSerr_r, .secSerr_r, .priMtExpire_r, .secMtExpire_r,
        .irq_r
    );
    brtc_agent agent (.ref_clk, .retryStop_r, .cycStart, .cycRetry, .cycDone, .cycIsPrimary);

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Sticky system error flags
    always @(posedge ref_clk)
    begin
        if (priSerr_r) priSeen <= 1'b1;
        if (secSerr_r) secSeen <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        lastB = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rdw

    // Start a master timeout and count cycles to its expiry
    task automatic mt(input logic sec, input int len);
        @(posedge ref_clk);
        {secMtStart, priMtStart} <= sec ? 2'b10 : 2'b01;
        @(posedge ref_clk);
        {secMtStart, priMtStart} <= 2'b00;
        n = 0;
        while ((sec ? secMtExpire_r : priMtExpire_r) !== 1'b1 && n < 40000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(n >= len && n <= len + 1, 1);
    endtask : mt

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Watchdog: the 4096-retry run dominates, about 20000 cycles in all
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        wrap_up;
    end

    initial
    begin
        logic [1:0] rr;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdw(8'h00, rd, rr);
        chk(rd, 0);
        rdw(8'h20, rd, rr);
        chk(rr, 2'b10);
        chk(rd, 0);
        wr(8'h24, 32'h1);
        chk(lastB, 2'b10);
        wr(8'h00, 32'h000000FF);
        chk(lastB, 2'b00);
        rdw(8'h00, rd, rr);
        chk(rd, 32'h000000F7);
        mtShortSel <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h00, {24'h0, c[1:0], c[1:0], 4'h0});
            mt(0, 1024 >> shf[c]);
            mt(1, 1024 >> shf[c]);
        end
        mtShortSel <= 1'b0;
        mt(0, 128);
        rdw(8'h04, rd, rr);
        chk(rd[3:0], 4'hC);
        wr(8'h08, 32'h0);
        repeat (3) @(posedge ref_clk);
        irqA = irq_r;
        wr(8'h08, 32'hF);
        repeat (3) @(posedge ref_clk);
        chk(irqA, 0);
        chk(irq_r, 1);
        wr(8'h04, 32'hF);
        repeat (3) @(posedge ref_clk);
        rdw(8'h04, rd, rr);
        chk(rd[3:0], 4'h0);
        chk(irq_r, 0);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h7);
        {priSeen, secSeen} = 2'b00;
        agent.run(1, 5, n);
        chk(n, 1);
        chk(priSeen, 1);
        wr(8'h00, 32'h3);
        agent.run(0, 100, n);
        chk(n, 64);
        chk(secSeen, 0);
        agent.run(1, 100, n);
        chk(n, 64);
        // Finished cycle leaves the count at zero
        rdw(8'h10, rd, rr);
        chk(rd, 0);
        wr(8'h00, 32'h2);
        agent.run(1, 4100, n);
        chk(n, 4096);
        // Long limits must not stop a short cycle
        wr(8'h00, 32'h1);
        agent.run(1, 100, n);
        chk(n, 100);
        wr(8'h00, 32'h0);
        agent.run(1, 100, n);
        chk(n, 100);
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h7);
        agent.run(0, 5, n);
        chk(n, 1);
        chk(secSeen, 1);
        wrap_up;
    end
endmodule : bridge_retry_timeout_control_test
